// File: rtl/hs_pkg.sv
package hs_pkg;

   localparam int NUM_PORTS = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [7:0] REG_PORT01_MODE = 8'h00;
   localparam logic [7:0] REG_PORT2_MODE  = 8'h04;
   localparam logic [7:0] REG_PORT3_MODE  = 8'h08;
   localparam logic [7:0] REG_DATA0       = 8'h0c;
   localparam logic [7:0] REG_DATA1       = 8'h10;
   localparam logic [7:0] REG_DATA2       = 8'h14;
   localparam logic [7:0] REG_IRQ_STAT    = 8'h18;
   localparam logic [7:0] REG_IRQ_MASK    = 8'h1c;
   localparam logic [7:0] REG_HS_STAT     = 8'h20;

   ////////////////////////////////////////////////////////////////////////////////
   // values after reset
   localparam logic [7:0] RST_PORT01_MODE = 8'h00;
   localparam logic [7:0] RST_PORT2_MODE  = 8'hff;
   localparam logic [7:0] RST_PORT3_MODE  = 8'h00;
   localparam logic       RST_HS_LINE     = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // mode bit positions
   localparam int P01_P0_IN   = 6;
   localparam int P01_P0_OUT  = 7;
   localparam int P01_P1_IN   = 3;
   localparam int P01_P1_OUT  = 4;
   localparam int P01_P0_LOA  = 0;
   localparam int P01_P0_LOB  = 1;
   localparam int P2M_P2_DIR  = 7;
   localparam int P3M_EN0     = 2;
   localparam int P3M_EN1A    = 3;
   localparam int P3M_EN1B    = 4;
   localparam int P3M_EN2     = 5;

   ////////////////////////////////////////////////////////////////////////////////
   // handshake pins of the fourth port, per data port 0..2
   localparam int HS_IN_PIN  [NUM_PORTS] = '{2, 3, 1};
   localparam int HS_OUT_PIN [NUM_PORTS] = '{5, 4, 6};
   localparam int P3_OUT_BASE            = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic enable;
      logic dir_in;
      logic wr;
      logic rd;
   } hs_ctrl_s;

   typedef struct packed {
      logic hs_out;
      logic full;
      logic fall;
   } hs_stat_s;

endpackage

// File: rtl/hs_port_engine.sv
`timescale 1ns/100ps

module hs_port_engine (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_ce,
   input  wire hs_pkg::hs_ctrl_s i_ctrl,
   input  wire logic             i_hs_in,
   output hs_pkg::hs_stat_s      o_stat
);

   typedef struct packed {
      logic prev_in;
      logic hs_out;
      logic full;
   } eng_state_s;

   eng_state_s st;
   eng_state_s next_st;
   logic       fall;
   logic       out_mode;
   logic       in_mode;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st  = st;
      out_mode = i_ctrl.enable && !i_ctrl.dir_in;
      in_mode  = i_ctrl.enable && i_ctrl.dir_in;
      fall     = i_ctrl.enable && st.prev_in && !i_hs_in;
      next_st.prev_in = i_hs_in;
      if (!i_ctrl.enable) begin
         next_st.hs_out = 1'b1;
         next_st.full   = 1'b0;
      end else if (i_ctrl.dir_in) begin
         if (fall) begin
            next_st.hs_out = 1'b0;
            next_st.full   = 1'b1;
         end else begin
            if (i_ctrl.rd) begin
               next_st.full = 1'b0;
            end
            if (!st.hs_out && i_hs_in && !st.full) begin
               next_st.hs_out = 1'b1;
            end
         end
      end else begin
         if (st.hs_out && st.full && i_hs_in) begin
            next_st.hs_out = 1'b0;
         end else if (!st.hs_out && !i_hs_in) begin
            next_st.hs_out = 1'b1;
            next_st.full   = 1'b0;
         end
         if (i_ctrl.wr) begin
            next_st.full = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st <= '{prev_in: hs_pkg::RST_HS_LINE, hs_out: hs_pkg::RST_HS_LINE, full: 1'b0};
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_stat = '{hs_out: st.hs_out, full: st.full, fall: fall && i_ce};

   ////////////////////////////////////////////////////////////////////////////////
   property p_dav_wait;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && out_mode && st.hs_out && !i_hs_in) |=> st.hs_out;
   endproperty
   a_dav_wait: assert property (p_dav_wait) else $error("strobe fell while ack low");

   property p_dav_drive;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && out_mode && st.hs_out && st.full && i_hs_in) |=> !st.hs_out;
   endproperty
   a_dav_drive: assert property (p_dav_drive) else $error("strobe not driven low");

   property p_dav_release;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && out_mode && !st.hs_out && !i_hs_in)
      |=> (st.hs_out && (!st.full || $past(i_ctrl.wr)));
   endproperty
   a_dav_release: assert property (p_dav_release) else $error("strobe not released");

   property p_dav_hold;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && out_mode && st.hs_out && !st.full && !i_ctrl.wr) |=> st.hs_out;
   endproperty
   a_dav_hold: assert property (p_dav_hold) else $error("strobe low without new byte");

   property p_idle;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && !i_ctrl.enable) |=> (st.hs_out && !st.full);
   endproperty
   a_idle: assert property (p_idle) else $error("handshake output not idle high");

   property p_in_take;
      @(posedge i_clk) disable iff (i_rst)
      (i_ce && in_mode && fall) |=> (!st.hs_out && st.full);
   endproperty
   a_in_take: assert property (p_in_take) else $error("input byte not taken");

   c_out_done: cover property (@(posedge i_clk) out_mode && !st.hs_out ##1 st.hs_out);
   c_in_done:  cover property (@(posedge i_clk) in_mode && fall);

endmodule // hs_port_engine

// File: rtl/port_strobe_handshake.sv
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps


module port_strobe_handshake (
   input  wire logic        I_CLK,
   input  wire logic        I_RST,
   input  wire logic        I_CE,
   input  wire logic        I_WB_CYC,
   input  wire logic        I_WB_STB,
   input  wire logic        I_WB_WE,
   input  wire logic [7:0]  I_WB_ADR,
   input  wire logic [3:0]  I_WB_SEL,
   input  wire logic [31:0] I_WB_DAT,
   output logic      [31:0] O_WB_DAT,
   output logic             O_WB_ACK,
   output logic             O_IRQ,
   input  wire logic [2:0][7:0] I_PORT,
   output logic      [2:0][7:0] O_PORT,
   output logic      [2:0][7:0] O_PORT_OE,
   input  wire logic [3:0]  I_P3_IN,
   output logic      [2:0]  O_P3_OUT
);

   typedef struct packed {
      logic [7:0]      port01_mode_reg;
      logic [7:0]      port2_mode_reg;
      logic [7:0]      port3_mode_reg;
      logic [2:0][7:0] data;
      logic [2:0]      hs_request;
      logic [2:0]      irq_mask;
      logic            ack;
      logic [7:0]      rdat;
      logic            irq;
      logic [2:0]      p3_out;
      logic [2:0][7:0] port_out;
      logic [2:0][7:0] port_oe;
   } top_state_s;

   top_state_s       st;
   top_state_s       next_st;
   hs_pkg::hs_ctrl_s ctrl [3];
   hs_pkg::hs_stat_s stat [3];
   logic [2:0]       en;
   logic [2:0]       valid;
   logic [2:0]       dir_in;
   logic [2:0]       fall;
   logic [2:0]       full;
   logic [2:0]       hs_out;
   logic             bus_acc;
   logic             bus_wr;
   logic             bus_rd;
   logic [7:0]       wdat;
   logic [2:0]       clr;

   ////////////////////////////////////////////////////////////////////////////////
   // mode decode
   always_comb begin
      en[0]     = st.port3_mode_reg[hs_pkg::P3M_EN0];
      en[1]     = st.port3_mode_reg[hs_pkg::P3M_EN1A]
                  && st.port3_mode_reg[hs_pkg::P3M_EN1B];
      en[2]     = st.port3_mode_reg[hs_pkg::P3M_EN2];
      dir_in[0] = st.port01_mode_reg[hs_pkg::P01_P0_IN]
                  && !st.port01_mode_reg[hs_pkg::P01_P0_OUT];
      valid[0]  = !st.port01_mode_reg[hs_pkg::P01_P0_OUT];
      dir_in[1] = st.port01_mode_reg[hs_pkg::P01_P1_IN]
                  && !st.port01_mode_reg[hs_pkg::P01_P1_OUT];
      valid[1]  = !st.port01_mode_reg[hs_pkg::P01_P1_OUT];
      dir_in[2] = st.port2_mode_reg[hs_pkg::P2M_P2_DIR];
      valid[2]  = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus strobes
   always_comb begin
      bus_acc = I_WB_CYC && I_WB_STB && !st.ack;
      bus_wr  = bus_acc && I_WB_WE && I_WB_SEL[0];
      bus_rd  = bus_acc && !I_WB_WE;
      wdat    = I_WB_DAT[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one engine per data port
   genvar gi;
   generate
      for (gi = 0; gi < hs_pkg::NUM_PORTS; gi++) begin : g_port
         localparam logic [7:0] DATA_ADR = 8'(hs_pkg::REG_DATA0 + 8'(4 * gi));
         always_comb begin
            ctrl[gi].enable = en[gi] && valid[gi];
            ctrl[gi].dir_in = dir_in[gi];
            ctrl[gi].wr     = bus_wr && (I_WB_ADR == DATA_ADR);
            ctrl[gi].rd     = bus_rd && (I_WB_ADR == DATA_ADR);
            fall[gi]        = stat[gi].fall;
            full[gi]        = stat[gi].full;
            hs_out[gi]      = stat[gi].hs_out;
         end
         hs_port_engine u_engine (
            .i_clk   (I_CLK),
            .i_rst   (I_RST),
            .i_ce    (I_CE),
            .i_ctrl  (ctrl[gi]),
            .i_hs_in (I_P3_IN[hs_pkg::HS_IN_PIN[gi]]),
            .o_stat  (stat[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // register file and pins
   always_comb begin
      next_st = st;
      clr     = 3'h0;
      next_st.ack = bus_acc;
      if (bus_wr) begin
         case (I_WB_ADR)
            hs_pkg::REG_PORT01_MODE: next_st.port01_mode_reg = wdat;
            hs_pkg::REG_PORT2_MODE:  next_st.port2_mode_reg  = wdat;
            hs_pkg::REG_PORT3_MODE:  next_st.port3_mode_reg  = wdat;
            hs_pkg::REG_DATA0:       next_st.data[0]         = wdat;
            hs_pkg::REG_DATA1:       next_st.data[1]         = wdat;
            hs_pkg::REG_DATA2:       next_st.data[2]         = wdat;
            hs_pkg::REG_IRQ_STAT:    clr                     = wdat[2:0];
            hs_pkg::REG_IRQ_MASK:    next_st.irq_mask        = wdat[2:0];
            default:                 next_st.irq_mask        = st.irq_mask;
         endcase
      end
      if (bus_rd) begin
         case (I_WB_ADR)
            hs_pkg::REG_PORT01_MODE: next_st.rdat = st.port01_mode_reg;
            hs_pkg::REG_PORT2_MODE:  next_st.rdat = st.port2_mode_reg;
            hs_pkg::REG_PORT3_MODE:  next_st.rdat = st.port3_mode_reg;
            hs_pkg::REG_DATA0:       next_st.rdat = st.data[0];
            hs_pkg::REG_DATA1:       next_st.rdat = st.data[1];
            hs_pkg::REG_DATA2:       next_st.rdat = st.data[2];
            hs_pkg::REG_IRQ_STAT:    next_st.rdat = {5'h00, st.hs_request};
            hs_pkg::REG_IRQ_MASK:    next_st.rdat = {5'h00, st.irq_mask};
            hs_pkg::REG_HS_STAT:     next_st.rdat = {2'h0, full, hs_out};
            default:                 next_st.rdat = 8'h00;
         endcase
      end
      for (int i = 0; i < hs_pkg::NUM_PORTS; i++) begin
         if (fall[i] && ctrl[i].dir_in) begin
            next_st.data[i] = I_PORT[i];
         end
         next_st.p3_out[hs_pkg::HS_OUT_PIN[i] - hs_pkg::P3_OUT_BASE] = hs_out[i];
         next_st.port_out[i] = st.data[i];
      end
      // request set wins over a clear in the same cycle
      next_st.hs_request = (st.hs_request & ~clr) | fall;
      next_st.irq        = |(next_st.hs_request & next_st.irq_mask);
      next_st.port_oe[0] = {
         {4{st.port01_mode_reg[hs_pkg::P01_P0_OUT:hs_pkg::P01_P0_IN] == 2'b00}},
         {4{st.port01_mode_reg[hs_pkg::P01_P0_LOB:hs_pkg::P01_P0_LOA] == 2'b00}}
      };
      next_st.port_oe[1] =
         {8{st.port01_mode_reg[hs_pkg::P01_P1_OUT:hs_pkg::P01_P1_IN] == 2'b00}};
      next_st.port_oe[2] = ~st.port2_mode_reg;
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         st                 <= '0;
         st.port01_mode_reg <= hs_pkg::RST_PORT01_MODE;
         st.port2_mode_reg  <= hs_pkg::RST_PORT2_MODE;
         st.port3_mode_reg  <= hs_pkg::RST_PORT3_MODE;
         st.p3_out          <= {3{hs_pkg::RST_HS_LINE}};
      end else if (I_CE) begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign O_WB_DAT  = {24'h000000, st.rdat};
   assign O_WB_ACK  = st.ack;
   assign O_IRQ     = st.irq;
   assign O_PORT    = st.port_out;
   assign O_PORT_OE = st.port_oe;
   assign O_P3_OUT  = st.p3_out;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   property p_req_set;
      @(posedge I_CLK) disable iff (I_RST)
      (I_CE && (fall != 3'h0)) |=> ((st.hs_request & $past(fall)) == $past(fall));
   endproperty
   a_req_set: assert property (p_req_set) else $error("handshake request lost");

   property p_p0_latch;
      @(posedge I_CLK) disable iff (I_RST)
      (I_CE && en[0] && st.port01_mode_reg[7:6] == 2'b01 && fall[0])
      |=> (st.data[0] == $past(I_PORT[0]));
   endproperty
   a_p0_latch: assert property (p_p0_latch) else $error("port 0 byte not latched");

   property p_p1_out;
      @(posedge I_CLK) disable iff (I_RST)
      (I_CE && st.port01_mode_reg[4:3] == 2'b00) |=> (O_PORT_OE[1] == 8'hff);
   endproperty
   a_p1_out: assert property (p_p1_out) else $error("port 1 not driven as output");

   property p_p2_in;
      @(posedge I_CLK) disable iff (I_RST)
      (I_CE && st.port2_mode_reg[7]) |=> !O_PORT_OE[2][7];
   endproperty
   a_p2_in: assert property (p_p2_in) else $error("port 2 high bit driven in input mode");

   property p_p3_idle;
      @(posedge I_CLK) disable iff (I_RST)
      (I_CE && !st.port3_mode_reg[5]) ##1 I_CE |=> O_P3_OUT[2];
   endproperty
   a_p3_idle: assert property (p_p3_idle) else $error("port 2 strobe low while disabled");

   c_irq: cover property (@(posedge I_CLK) disable iff (I_RST) !O_IRQ ##1 O_IRQ);

endmodule // port_strobe_handshake

// File: tb/periph_model.sv
`timescale 1ns/100ps

// attached peripheral on the output handshake: latch on low strobe, then pull ack low
module periph_model #(
   parameter int DELAY = 3
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_strobe_n,
   input  wire logic       i_stall,
   input  wire logic [7:0] i_data,
   output logic            o_ack,
   output logic [7:0]      o_byte,
   output logic [7:0]      o_count
);
   logic [3:0] wait_cnt;
   logic       busy;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ack    <= 1'b1;
         busy     <= 1'b0;
         wait_cnt <= 4'h0;
         o_byte   <= 8'h00;
         o_count  <= 8'h00;
      end else if (!busy && !i_strobe_n && o_ack) begin
         o_byte   <= i_data;
         busy     <= 1'b1;
         wait_cnt <= 4'h0;
      end else if (busy && o_ack) begin
         wait_cnt <= wait_cnt + 4'h1;
         if (wait_cnt == 4'(DELAY)) begin
            o_ack   <= 1'b0;
            o_count <= o_count + 8'h01;
         end
      end else if (busy && i_strobe_n && !i_stall) begin
         o_ack <= 1'b1;
         busy  <= 1'b0;
      end
   end
endmodule // periph_model

// File: tb/port_strobe_handshake_test.sv
`timescale 1ns/100ps

module port_strobe_handshake_test;
   logic             I_CLK, I_RST, cyc, stb, we, stall, ack2;
   logic [7:0]       adr, pbyte, pcount;
   logic [31:0]      wdat, rd, O_WB_DAT;
   logic             O_WB_ACK, O_IRQ;
   logic [1:0]       hs_in;
   logic [2:0][7:0]  port_in, O_PORT, O_PORT_OE;
   logic [2:0]       O_P3_OUT;
   int               num_errors, cmp_count, cyc_cnt;

   port_strobe_handshake u_port_strobe_handshake (
      .I_CLK(I_CLK), .I_RST(I_RST), .I_CE(1'b1), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'h1), .I_WB_DAT(wdat),
      .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_IRQ(O_IRQ), .I_PORT(port_in),
      .O_PORT(O_PORT), .O_PORT_OE(O_PORT_OE), .I_P3_IN({hs_in, ack2, 1'b1}),
      .O_P3_OUT(O_P3_OUT));

   periph_model u_periph_model (
      .i_clk(I_CLK), .i_rst(I_RST), .i_strobe_n(O_P3_OUT[2]), .i_stall(stall),
      .i_data(O_PORT[2]), .o_ack(ack2), .o_byte(pbyte), .o_count(pcount));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      I_CLK = 1'b0;
      forever #5 I_CLK = ~I_CLK;
   end

   always @(posedge I_CLK) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // classic single wishbone cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge I_CLK);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge I_CLK);
      end while (O_WB_ACK !== 1'b1);
      rd  = O_WB_DAT;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wait_count(input logic [7:0] n);
      while (pcount !== n) @(posedge I_CLK);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge I_CLK);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic hi;
      I_RST = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0;
      stall = 1'b0; hs_in = 2'b11; port_in = '0;
      cycles(8);
      I_RST <= 1'b0;
      cycles(2);
      chk(32'(O_P3_OUT), 32'h7);
      wb(1'b0, hs_pkg::REG_PORT2_MODE, 32'h0);
      chk(rd, 32'hff);
      wb(1'b0, 8'hfc, 32'h0);
      chk(rd, 32'h0);
      // port 2 output handshake
      wb(1'b1, hs_pkg::REG_PORT2_MODE, 32'h00);
      wb(1'b1, hs_pkg::REG_IRQ_MASK, 32'h07);
      wb(1'b1, hs_pkg::REG_PORT3_MODE, 32'h20);
      chk(32'(O_P3_OUT[2]), 32'h1);
      wb(1'b1, hs_pkg::REG_DATA2, 32'ha5);
      wait_count(8'h01);
      chk(32'(pbyte), 32'ha5);
      cycles(4);
      chk(32'(O_IRQ), 32'h1);
      wb(1'b0, hs_pkg::REG_IRQ_STAT, 32'h0);
      chk(rd & 32'h4, 32'h4);
      cycles(10);
      chk(32'(O_P3_OUT[2]), 32'h1);
      wb(1'b1, hs_pkg::REG_IRQ_STAT, 32'h04);
      wb(1'b0, hs_pkg::REG_IRQ_STAT, 32'h0);
      chk(rd & 32'h4, 32'h0);
      chk(32'(O_IRQ), 32'h0);
      // ack held low by the peripheral: strobe must wait
      stall <= 1'b1;
      wb(1'b1, hs_pkg::REG_DATA2, 32'h5a);
      wait_count(8'h02);
      chk(32'(pbyte), 32'h5a);
      cycles(4);
      wb(1'b1, hs_pkg::REG_DATA2, 32'h3c);
      hi = 1'b1;
      repeat (12) begin
         @(posedge I_CLK);
         hi = hi & O_P3_OUT[2];
      end
      chk(32'(hi), 32'h1);
      stall <= 1'b0;
      wait_count(8'h03);
      chk(32'(pbyte), 32'h3c);
      // ports 0 and 1 input handshake
      wb(1'b1, hs_pkg::REG_PORT01_MODE, 32'h48);
      wb(1'b1, hs_pkg::REG_PORT3_MODE, 32'h3c);
      chk(32'(O_PORT_OE), 32'hff000f);
      for (int k = 0; k < 2; k++) begin
         @(posedge I_CLK);
         port_in[k] <= 8'(8'h61 + k * 8'h17);
         @(posedge I_CLK);
         hs_in[k] <= 1'b0;
         cycles(4);
         chk(32'(O_P3_OUT[1 - k]), 32'h0);
         wb(1'b0, 8'(hs_pkg::REG_DATA0 + 4 * k), 32'h0);
         chk(rd, 32'(8'h61 + k * 8'h17));
         wb(1'b0, hs_pkg::REG_IRQ_STAT, 32'h0);
         chk(rd & 32'(1 << k), 32'(1 << k));
         hs_in[k] <= 1'b1;
         cycles(4);
         chk(32'(O_P3_OUT[1 - k]), 32'h1);
      end
      // port 0 output handshake, ack driven by the bench
      wb(1'b1, hs_pkg::REG_PORT01_MODE, 32'h00);
      wb(1'b1, hs_pkg::REG_IRQ_STAT, 32'h07);
      wb(1'b0, hs_pkg::REG_IRQ_STAT, 32'h0);
      chk(rd & 32'h1, 32'h0);
      wb(1'b1, hs_pkg::REG_DATA0, 32'h9c);
      cycles(3);
      chk(32'(O_P3_OUT[1]), 32'h0);
      chk(32'(O_PORT[0]), 32'h9c);
      hs_in[0] <= 1'b0;
      cycles(4);
      chk(32'(O_P3_OUT[1]), 32'h1);
      wb(1'b0, hs_pkg::REG_IRQ_STAT, 32'h0);
      chk(rd & 32'h1, 32'h1);
      hs_in[0] <= 1'b1;
      cycles(2);
      report_and_stop();
   end
endmodule // port_strobe_handshake_test
